// *** hdl/dtgi_timer.sv ***
// Dual timer top: Timer0 with shared prescaler, gated 16-bit Timer1, interrupts.
//
// Overview of operation
// - Timer0 counts its external pin when source select is 1, else the internal clock.
// - On the external pin Timer0 counts falling edges if edge select is 1, else rising.
// - Timer1 gate comes from gate pin, alternate gate pin or comparator output.
// - Gating acts only while the Timer1 gate enable bit is set.
// - Gate invert bit inverts the chosen gate whatever its source.
// - The 16-bit Timer1 counts up to FFFF and wraps to 0000.
// - Every Timer1 wrap sets the Timer1 rollover flag.
// - Timer1 interrupt needs rollover enable, peripheral and global enables set.
// - The rollover flag stays set until software clears it.
// - General pin five serves as the Timer1 external clock input.
// - In sleep only external asynchronous Timer1 counts; its wrap wakes the device if rollover and peripheral enables are set.
`timescale 1ns/1ps
`include "dtgi_defines.svh"
module dtgi_timer (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic      [7:0] bus_rdata,
  input  wire logic       timer0_ext_clock_pin,
  input  wire logic       general_pin_five,
  input  wire logic       timer1_gate_pin,
  input  wire logic       timer1_gate_alt_pin,
  input  wire logic       comparator_output,
  input  wire logic       sleep_mode,
  input  wire logic       wdt_tick,
  output logic            wdt_scaled_tick,
  output logic            irq,
  output logic            wake
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode.

  logic [7:0]  timer0_q;
  logic [7:0]  timer0_d;
  logic [7:0]  intctl_q;
  logic [7:0]  intctl_d;
  logic [7:0]  option_q;
  logic [15:0] t1_q;
  logic [15:0] t1_d;
  logic [7:0]  t1ctl_q;
  logic [7:0]  cmp1_q;
  logic        pen_q;
  logic        altsel_q;
  logic        t1if_q;
  logic        t1if_d;
  logic        irq_d;
  logic        wake_d;
  logic        wdt_scaled_d;
  logic [7:0]  rd_mux;

  wire wr_t0    = bus_wr && (bus_addr == `DTGI_ADDR_TIMER0);
  wire wr_int   = bus_wr && (bus_addr == `DTGI_ADDR_INTCTL);
  wire wr_pflag = bus_wr && (bus_addr == `DTGI_ADDR_PFLAG);
  wire wr_t1lo  = bus_wr && (bus_addr == `DTGI_ADDR_T1LO);
  wire wr_t1hi  = bus_wr && (bus_addr == `DTGI_ADDR_T1HI);
  wire wr_t1ctl = bus_wr && (bus_addr == `DTGI_ADDR_T1CTL);
  wire wr_cmp1  = bus_wr && (bus_addr == `DTGI_ADDR_CMP1);
  wire wr_opt   = bus_wr && (bus_addr == `DTGI_ADDR_OPTION);
  wire wr_pen   = bus_wr && (bus_addr == `DTGI_ADDR_PEN);
  wire wr_alt   = bus_wr && (bus_addr == `DTGI_ADDR_ALTSEL);
  wire wr_t1any = wr_t1lo || wr_t1hi;

  ////////////////////////////////////////////////////////////////////////////////
  // Timer0 and the shared prescaler.

  dtgi_tick_if pre0 ();
  dtgi_tick_if pre1 ();
  logic t0_edge;
  logic t1_edge;

  dtgi_edge_det u_t0_edge (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin      (timer0_ext_clock_pin),
    .on_fall  (option_q[`DTGI_OPT_SE]),
    .edge_hit (t0_edge)
  );

  dtgi_prescaler u_pre0 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tk      (pre0.pre)
  );

  dtgi_pkg::dtgi_pre_owner_type pre_owner;
  assign pre_owner = option_q[`DTGI_OPT_PSA] ? dtgi_pkg::DTGI_PRE_WATCHDOG
                                             : dtgi_pkg::DTGI_PRE_TIMER0;
  wire owner_t0 = (pre_owner == dtgi_pkg::DTGI_PRE_TIMER0);

  // Timer0 is a synchronous counter and therefore halts in sleep.
  wire t0_raw = !sleep_mode && (option_q[`DTGI_OPT_CS] ? t0_edge : 1'b1);

  assign pre0.tick  = owner_t0 ? t0_raw : wdt_tick;
  assign pre0.shift = owner_t0 ? 4'({1'b0, option_q[2:0]} + 4'h1)
                               : {1'b0, option_q[2:0]};
  // Retiming or reassigning the prescaler restarts it so no stale count leaks across.
  assign pre0.clear = (wr_t0 && owner_t0) || wr_opt;

  wire t0_inc = owner_t0 ? pre0.scaled : t0_raw;
  wire t0_ovf = t0_inc && !wr_t0 && (timer0_q == 8'hFF);

  assign wdt_scaled_d = owner_t0 ? wdt_tick : pre0.scaled;
  assign timer0_d     = wr_t0 ? bus_wdata : (t0_inc ? timer0_q + 8'h01 : timer0_q);

  // Overflow sets the flag even in the cycle software writes the register.
  assign intctl_d = wr_int ? (bus_wdata | {5'h00, t0_ovf, 2'h0})
                           : (intctl_q | {5'h00, t0_ovf, 2'h0});

  ////////////////////////////////////////////////////////////////////////////////
  // Timer1 gate, clock and counter.

  dtgi_edge_det u_t1_edge (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin      (general_pin_five),
    .on_fall  (1'b0),
    .edge_hit (t1_edge)
  );

  dtgi_prescaler u_pre1 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tk      (pre1.pre)
  );

  dtgi_pkg::dtgi_gate_src_type gate_src;
  assign gate_src = !cmp1_q[`DTGI_CMP1_GSS] ? dtgi_pkg::DTGI_GATE_COMP
                  : (altsel_q ? dtgi_pkg::DTGI_GATE_ALT : dtgi_pkg::DTGI_GATE_PIN);

  wire gate_raw = (gate_src == dtgi_pkg::DTGI_GATE_COMP) ? comparator_output
                : (gate_src == dtgi_pkg::DTGI_GATE_ALT)  ? timer1_gate_alt_pin
                                                         : timer1_gate_pin;

  // The gate is active low by default; the invert bit makes it active high.
  wire gate_open = t1ctl_q[`DTGI_T1_GINV] ? gate_raw : ~gate_raw;
  wire t1_run    = t1ctl_q[`DTGI_T1_ON] && (!t1ctl_q[`DTGI_T1_GE] || gate_open);
  wire t1_ext    = t1ctl_q[`DTGI_T1_CS];

  // Only an unsynchronised external clock keeps running while the core sleeps.
  wire t1_src = sleep_mode ? (t1_ext && t1ctl_q[`DTGI_T1_SYNC] && t1_edge)
                           : (t1_ext ? t1_edge : 1'b1);

  assign pre1.tick  = t1_run && t1_src;
  assign pre1.shift = {2'b00, t1ctl_q[5:4]};
  assign pre1.clear = wr_t1any;

  wire t1_inc  = pre1.scaled;
  wire t1_wrap = t1_inc && !wr_t1any && (t1_q == 16'hFFFF);

  assign t1_d = wr_t1lo ? {t1_q[15:8], bus_wdata}
              : wr_t1hi ? {bus_wdata, t1_q[7:0]}
              : (t1_inc ? t1_q + 16'h0001 : t1_q);

  // A wrap in the clearing cycle keeps the flag set.
  assign t1if_d = t1_wrap || (t1if_q && !(wr_pflag && bus_wdata[`DTGI_FLAG_T1]));

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt, wake and read data.

  wire global_irq_enable  = intctl_q[`DTGI_INT_GIE];
  wire peripheral_irq_enable = intctl_q[`DTGI_INT_PERIPHERAL_IRQ_ENABLE];

  assign irq_d = global_irq_enable && ((t1if_q && pen_q && peripheral_irq_enable)
                      || (intctl_q[`DTGI_INT_T0IF] && intctl_q[`DTGI_INT_T0IE]));
  assign wake_d = sleep_mode && t1if_q && pen_q && peripheral_irq_enable && t1ctl_q[`DTGI_T1_ON];

  assign rd_mux = (bus_addr == `DTGI_ADDR_TIMER0) ? timer0_q
                : (bus_addr == `DTGI_ADDR_INTCTL) ? intctl_q
                : (bus_addr == `DTGI_ADDR_PFLAG)  ? {7'h00, t1if_q}
                : (bus_addr == `DTGI_ADDR_T1LO)   ? t1_q[7:0]
                : (bus_addr == `DTGI_ADDR_T1HI)   ? t1_q[15:8]
                : (bus_addr == `DTGI_ADDR_T1CTL)  ? t1ctl_q
                : (bus_addr == `DTGI_ADDR_CMP1)   ? cmp1_q
                : (bus_addr == `DTGI_ADDR_OPTION) ? option_q
                : (bus_addr == `DTGI_ADDR_PEN)    ? {7'h00, pen_q}
                : (bus_addr == `DTGI_ADDR_ALTSEL) ? {3'h0, altsel_q, 4'h0}
                                                  : 8'h00;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      timer0_q <= 8'h00;
      intctl_q <= `DTGI_RST_INTCTL;
      option_q <= `DTGI_RST_OPTION;
      t1_q     <= 16'h0000;
      t1ctl_q  <= `DTGI_RST_T1CTL;
      cmp1_q   <= `DTGI_RST_CMP1;
      pen_q    <= 1'b0;
      altsel_q <= 1'b0;
      t1if_q   <= 1'b0;
    end
    else
    begin
      timer0_q <= timer0_d;
      intctl_q <= intctl_d;
      t1_q     <= t1_d;
      t1if_q   <= t1if_d;
      if (wr_opt)
        option_q <= bus_wdata;
      if (wr_t1ctl)
        t1ctl_q <= bus_wdata;
      if (wr_cmp1)
        cmp1_q <= bus_wdata & `DTGI_CMP1_MASK;
      if (wr_pen)
        pen_q <= bus_wdata[`DTGI_FLAG_T1];
      if (wr_alt)
        altsel_q <= bus_wdata[`DTGI_ALT_GATE];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_rdata       <= 8'h00;
      irq             <= 1'b0;
      wake            <= 1'b0;
      wdt_scaled_tick <= 1'b0;
    end
    else
    begin
      bus_rdata       <= bus_rd ? rd_mux : 8'h00;
      irq             <= irq_d;
      wake            <= wake_d;
      wdt_scaled_tick <= wdt_scaled_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence t1_at_top;
    (t1_q == 16'hFFFF) && !wr_t1any;
  endsequence

  sequence t1_moved;
    (t1_q != 16'hFFFF);
  endsequence

  a_t0_internal_count: assert property (
    (!option_q[`DTGI_OPT_CS] && option_q[`DTGI_OPT_PSA] && !wr_t0 && !sleep_mode)
      |=> timer0_q == $past(timer0_q) + 8'h01)
    else $error("Timer0 missed an internal count.");

  a_t0_fall_edge: assert property (
    (option_q[`DTGI_OPT_CS] && option_q[`DTGI_OPT_SE] && option_q[`DTGI_OPT_PSA]
     && !wr_t0 && !sleep_mode && $past(!sys_rst) && $fell(timer0_ext_clock_pin))
      |=> timer0_q == $past(timer0_q) + 8'h01)
    else $error("Timer0 missed a falling edge.");

  a_wdt_pass_raw: assert property (
    !option_q[`DTGI_OPT_PSA] |=> wdt_scaled_tick == $past(wdt_tick))
    else $error("Watchdog tick was prescaled while Timer0 owns the prescaler.");

  a_t0_ratio_min: assert property (
    (!option_q[`DTGI_OPT_PSA] && pre0.scaled && !wr_opt) |=> !pre0.scaled)
    else $error("Timer0 prescale ratio fell below two.");

  a_gate_pin_hold: assert property (
    (t1ctl_q[`DTGI_T1_ON] && t1ctl_q[`DTGI_T1_GE] && !t1ctl_q[`DTGI_T1_GINV]
     && cmp1_q[`DTGI_CMP1_GSS] && !altsel_q && timer1_gate_pin && !wr_t1any)
      |=> $stable(t1_q))
    else $error("Timer1 counted with its gate closed.");

  a_t1_wrap_flag: assert property (
    t1_at_top ##1 t1_moved |-> (t1_q == 16'h0000) && t1if_q)
    else $error("Timer1 wrap wrong or flag not set.");

  a_flag_sticky: assert property (
    (t1if_q && !(wr_pflag && bus_wdata[`DTGI_FLAG_T1])) |=> t1if_q)
    else $error("Rollover flag dropped without a clear.");

  a_irq_enables: assert property (
    (t1if_q && pen_q && peripheral_irq_enable && global_irq_enable) |=> irq)
    else $error("Enabled rollover did not raise the interrupt.");

  a_irq_global_off: assert property (
    !global_irq_enable |=> !irq)
    else $error("Interrupt raised with global enable clear.");

  a_sleep_hold: assert property (
    (sleep_mode && !t1_ext && !wr_t1any) |=> $stable(t1_q))
    else $error("Timer1 counted the internal clock in sleep.");

  a_pin_five_count: assert property (
    (t1ctl_q[`DTGI_T1_ON] && t1_ext && !t1ctl_q[`DTGI_T1_GE] && (t1ctl_q[5:4] == 2'b00)
     && !sleep_mode && !wr_t1any && $rose(general_pin_five))
      |=> t1_q == $past(t1_q) + 16'h0001)
    else $error("Timer1 missed a rising edge on general pin five.");

endmodule

// *** hdl/dtgi_defines.svh ***
// Register offsets, field positions and reset values of the dual timer block.
`ifndef DTGI_DEFINES_SVH
`define DTGI_DEFINES_SVH

`define DTGI_ADDR_TIMER0     8'h01
`define DTGI_ADDR_INTCTL     8'h0B
`define DTGI_ADDR_PFLAG      8'h0C
`define DTGI_ADDR_T1LO       8'h0E
`define DTGI_ADDR_T1HI       8'h0F
`define DTGI_ADDR_T1CTL      8'h10
`define DTGI_ADDR_CMP1       8'h1C
`define DTGI_ADDR_OPTION     8'h20
`define DTGI_ADDR_PEN        8'h21
`define DTGI_ADDR_ALTSEL     8'h22

`define DTGI_RST_OPTION      8'hFF
`define DTGI_RST_INTCTL      8'h00
`define DTGI_RST_T1CTL       8'h00
`define DTGI_RST_CMP1        8'h02
`define DTGI_CMP1_MASK       8'h1B

`define DTGI_INT_GIE         7
`define DTGI_INT_PERIPHERAL_IRQ_ENABLE        6
`define DTGI_INT_T0IE        5
`define DTGI_INT_T0IF        2
`define DTGI_OPT_CS          5
`define DTGI_OPT_SE          4
`define DTGI_OPT_PSA         3
`define DTGI_T1_GINV         7
`define DTGI_T1_GE           6
`define DTGI_T1_SYNC         2
`define DTGI_T1_CS           1
`define DTGI_T1_ON           0
`define DTGI_CMP1_GSS        1
`define DTGI_ALT_GATE        4
`define DTGI_FLAG_T1         0

`endif

// *** hdl/dtgi_pkg.sv ***
// Types and the shared helper function of the dual timer block.
package dtgi_pkg;

  typedef enum logic {DTGI_PRE_TIMER0, DTGI_PRE_WATCHDOG} dtgi_pre_owner_type;

  typedef enum logic [1:0] {DTGI_GATE_COMP, DTGI_GATE_PIN, DTGI_GATE_ALT} dtgi_gate_src_type;

  function automatic logic [7:0] dtgi_low_mask(input logic [3:0] shift);
    logic [8:0] one_hot;
    one_hot = 9'h001 << shift;
    return 8'(one_hot - 9'h001);
  endfunction

endpackage

// *** hdl/dtgi_tick_if.sv ***
// Tick bundle between a timer and its prescaler.
`timescale 1ns/1ps
interface dtgi_tick_if;
  logic       tick;
  logic       clear;
  logic [3:0] shift;
  logic       scaled;
  modport ctrl (output tick, output clear, output shift, input scaled);
  modport pre  (input tick, input clear, input shift, output scaled);
endinterface

// *** hdl/dtgi_edge_det.sv ***
// Edge detector for an external count pin, rising or falling selectable.
`timescale 1ns/1ps
module dtgi_edge_det (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin,
  input  wire logic on_fall,
  output logic      edge_hit
);

  logic prev_q;

  always_ff @(posedge clk)
  begin
    // Loading the pin itself keeps a pin that idles high from faking an edge after reset.
    if (sys_rst)
      prev_q <= pin;
    else
      prev_q <= pin;
  end

  assign edge_hit = on_fall ? (prev_q & ~pin) : (~prev_q & pin);

endmodule

// *** hdl/dtgi_prescaler.sv ***
// Power-of-two prescaler; passes one tick out of two to the power of shift.
`timescale 1ns/1ps
module dtgi_prescaler (
  input  wire logic clk,
  input  wire logic sys_rst,
  dtgi_tick_if.pre  tk
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  wire  [7:0] mask = dtgi_pkg::dtgi_low_mask(tk.shift);

  // The counter is cleared on tk.clear, which Timer0 raises on retiming, so a new ratio starts from a full period.
  assign tk.scaled = tk.tick && !tk.clear && ((cnt_q & mask) == mask);
  assign cnt_d     = tk.clear ? 8'h00 : (tk.tick ? cnt_q + 8'h01 : cnt_q);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_d;
  end

endmodule

// *** dv/dtgi_pins_model.sv ***
// Far-side pin model: Timer0 count pin level and bursts of clock pulses on general pin five.
`timescale 1ns/1ps
module dtgi_pins_model (
  input  wire logic       clk,
  input  wire logic       t0_level,
  input  wire logic       go,
  input  wire logic [3:0] pulses,
  output logic            timer0_ext_clock_pin,
  output logic            general_pin_five,
  output logic            busy
);
  logic [4:0] half_q;
  logic       slow_q;
  assign timer0_ext_clock_pin = t0_level;
  assign busy                 = (half_q != 5'h00);
  initial
  begin
    half_q = 5'h00;
    slow_q = 1'b0;
    general_pin_five = 1'b0;
  end
  // The pin rests low between bursts, so no stray edge reaches Timer1.
  always @(posedge clk)
  begin
    slow_q <= ~slow_q;
    if (go)
      half_q <= {pulses, 1'b0};
    else if (busy && slow_q)
    begin
      half_q <= half_q - 5'h01;
      general_pin_five <= ~general_pin_five;
    end
  end
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the dual timer block.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} dtgi_row_type;
  logic       clk, sys_rst, bus_wr, bus_rd, t0_level, go, t0pin, gp5, busy;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, v0, v1;
  logic [3:0] pulses;
  logic       gate_pin, alt_pin, comp, sleep_mode, wdt_tick, wdt_scaled, irq, wake;
  int         fails, n_tests, cycles, wdt_cnt, lvl;
  dtgi_row_type rows [14] = '{'{8'h0B, 1'b0, 8'h00, 8'h00}, '{8'h0C, 1'b0, 8'h00, 8'h00},
    '{8'h10, 1'b0, 8'h00, 8'h00}, '{8'h1C, 1'b0, 8'h00, 8'h02}, '{8'h20, 1'b0, 8'h00, 8'hFF},
    '{8'h21, 1'b0, 8'h00, 8'h00}, '{8'h22, 1'b0, 8'h00, 8'h00}, '{8'h05, 1'b0, 8'h00, 8'h00},
    '{8'h1C, 1'b1, 8'hFF, 8'h1B}, '{8'h21, 1'b1, 8'hFF, 8'h01}, '{8'h22, 1'b1, 8'hFF, 8'h10},
    '{8'h05, 1'b1, 8'hAA, 8'h00}, '{8'h10, 1'b1, 8'h3C, 8'h3C}, '{8'h10, 1'b1, 8'h00, 8'h00}};
  dtgi_timer uut (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .timer0_ext_clock_pin(t0pin),
    .general_pin_five(gp5), .timer1_gate_pin(gate_pin), .timer1_gate_alt_pin(alt_pin),
    .comparator_output(comp), .sleep_mode(sleep_mode), .wdt_tick(wdt_tick),
    .wdt_scaled_tick(wdt_scaled), .irq(irq), .wake(wake));
  dtgi_pins_model pins (.clk(clk), .t0_level(t0_level), .go(go), .pulses(pulses),
    .timer0_ext_clock_pin(t0pin), .general_pin_five(gp5), .busy(busy));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  // Two reads whose taking edges lie n cycles apart; d is the count gained between them.
  task automatic span(input logic [7:0] a, input int n, output logic [7:0] d);
    logic [7:0] s0, s1;
    rd(a, s0);
    repeat (n - 2) @(posedge clk);
    rd(a, s1);
    d = s1 - s0;
  endtask
  task automatic burst(input logic [3:0] n);
    int k;
    @(posedge clk);
    go <= 1'b1;
    pulses <= n;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 200 && (busy !== 1'b0 || k < 2); k++)
      @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (wdt_scaled === 1'b1)
      wdt_cnt++;
    if (cycles == 40000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    {sys_rst, bus_wr, bus_rd, go, t0_level, wdt_tick, sleep_mode} = 7'h40;
    {bus_addr, bus_wdata, pulses} = 20'h00000;
    {gate_pin, alt_pin, comp} = 3'h0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v0);
      check("register", v0, rows[i].e);
    end
    $display("register table done");
    wr(8'h20, 8'h0F);
    span(8'h01, 64, v0);
    check("timer0 internal", v0, 8'h40);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h20, 8'(c));
      span(8'h01, 256, v0);
      check("timer0 rate", v0, 8'(256 >> (c + 1)));
      wr(8'h20, 8'(8 + c));
      wdt_cnt = 0;
      repeat (16)
      begin
        @(posedge clk) wdt_tick <= 1'b1;
        @(posedge clk) wdt_tick <= 1'b0;
      end
      repeat (3) @(posedge clk);
      check("watchdog rate", 8'(wdt_cnt), 8'(16 >> c));
    end
    for (int e = 0; e < 2; e++)
    begin
      wr(8'h20, e ? 8'h38 : 8'h28);
      rd(8'h01, v0);
      t0_level <= 1'b1;
      repeat (4) @(posedge clk);
      rd(8'h01, v1);
      check("timer0 rise", v1 - v0, e ? 8'h00 : 8'h01);
      t0_level <= 1'b0;
      repeat (4) @(posedge clk);
      rd(8'h01, v0);
      check("timer0 fall", v0 - v1, e ? 8'h01 : 8'h00);
    end
    $display("timer0 done");
    for (int s = 0; s < 3; s++)
      for (int g = 0; g < 4; g++)
      begin
        lvl = g & 1;
        wr(8'h1C, s == 0 ? 8'h00 : 8'h02);
        wr(8'h22, s == 2 ? 8'h10 : 8'h00);
        wr(8'h10, g[1] ? 8'hC1 : 8'h41);
        comp <= (s == 0) ? lvl[0] : ~lvl[0];
        gate_pin <= (s == 1) ? lvl[0] : ~lvl[0];
        alt_pin <= (s == 2) ? lvl[0] : ~lvl[0];
        span(8'h0E, 64, v0);
        check("timer1 gate", v0, (g[1] ~^ lvl[0]) ? 8'h40 : 8'h00);
      end
    wr(8'h10, 8'h01);
    span(8'h0E, 64, v0);
    check("timer1 ungated", v0, 8'h40);
    wr(8'h10, 8'h31);
    span(8'h0E, 64, v0);
    check("timer1 prescale", v0, 8'h08);
    wr(8'h10, 8'h03);
    rd(8'h0E, v0);
    burst(4'h5);
    rd(8'h0E, v1);
    check("timer1 pin five", v1 - v0, 8'h05);
    $display("timer1 gate and clock done");
    wr(8'h10, 8'h00);
    wr(8'h0F, 8'hFF);
    wr(8'h0E, 8'hF0);
    wr(8'h0C, 8'h01);
    wr(8'h21, 8'h01);
    wr(8'h0B, 8'hC0);
    #1 check("irq idle", irq, 8'h00);
    wr(8'h10, 8'h01);
    repeat (30) @(posedge clk);
    wr(8'h10, 8'h00);
    rd(8'h0F, v0);
    check("timer1 wrap", v0, 8'h00);
    rd(8'h0C, v0);
    check("rollover flag", v0, 8'h01);
    check("irq on", irq, 8'h01);
    wr(8'h0B, 8'h80);
    repeat (2) @(posedge clk);
    #1 check("irq no peripheral", irq, 8'h00);
    wr(8'h0B, 8'h40);
    repeat (2) @(posedge clk);
    #1 check("irq no global", irq, 8'h00);
    rd(8'h0C, v0);
    check("flag held", v0, 8'h01);
    wr(8'h0B, 8'hC0);
    wr(8'h0C, 8'h01);
    repeat (2) @(posedge clk);
    #1 check("irq cleared", irq, 8'h00);
    rd(8'h0C, v0);
    check("flag cleared", v0, 8'h00);
    $display("interrupt done");
    wr(8'h0B, 8'h40);
    wr(8'h10, 8'h01);
    sleep_mode <= 1'b1;
    span(8'h0E, 16, v0);
    check("sleep internal", v0, 8'h00);
    wr(8'h0F, 8'hFF);
    wr(8'h0E, 8'hFF);
    wr(8'h10, 8'h07);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check("no early wake", wake, 8'h00);
    burst(4'h1);
    #1 check("wake", wake, 8'h01);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    sleep_mode <= 1'b0;
    rd(8'h20, v0);
    check("option after reset", v0, 8'hFF);
    check("wake after reset", wake, 8'h00);
    $display("sleep and reset done");
    give_verdict();
  end
endmodule
